// *** logic/sso_map.svh ***
// Offsets, field positions, reset values and constants of the status outputs
`ifndef SSO_MAP_SVH
`define SSO_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSO_CTRL_OFS    8'h00
`define SSO_RANGE_OFS   8'h04
`define SSO_TOL_OFS     8'h08
`define SSO_ASSIGN_OFS  8'h0c
`define SSO_FLAGS_OFS   8'h10
`define SSO_IST_OFS     8'h14
`define SSO_ICLR_OFS    8'h18
`define SSO_IEN_OFS     8'h1c
// ----------------------------------------
// Fields, reset values and the low-speed constant
// ----------------------------------------
`define SSO_CTRL_MODE_BIT 0
`define SSO_EV_INP        0
`define SSO_EV_RDY        1
`define SSO_EV_SA         2
`define SSO_EV_BRAKE      3
`define SSO_RANGE_RST     16'h0064
`define SSO_TOL_RST       16'h000a
`define SSO_ASSIGN_RST    6'h00
`define SSO_SA_LOW_RPM    16'h0014
`endif

// *** logic/sso_pkg.sv ***
// Types of the status outputs block
package sso_pkg;
  typedef enum logic {SSO_LOOP_POS, SSO_LOOP_SPEED} sso_loop_t;
  typedef enum logic [1:0] {SSO_SEL_NONE, SSO_SEL_RDY, SSO_SEL_DBI, SSO_SEL_SA} sso_sel_t;
endpackage : sso_pkg

// *** logic/sso_status_outputs.sv ***
// Status outputs of a servo driver: in-position, ready, brake interlock, speed reached
//
// Functional notes
// R1: In-position on while droop magnitude lies inside configured range.
// R2: In-position on in the cycle after servo-on becomes active.
// R3: In-position held off in speed loop mode.
// R4: Host assigns ready, interlock, speed-reached to pins before use.
// R5: Ready on only with servo on and driver prepared.
// R6: Interlock drops on the same edge the dynamic brake engages.
// R7: Host uses interlock with external brake on large drivers only.
// R8: Speed-reached held off while servo is off.
// R9: Speed-reached on when measured speed is near commanded speed.
// R10: Speed-reached on with servo on in speed loop mode whenever commanded speed is 20 r/min or less.
// R11: Speed-reached held off in position loop mode.
// R12: In-position drops when droop leaves range, unless servo-on edge holds it.
`timescale 1ns/10ps
`include "sso_map.svh"
module sso_status_outputs #(
  parameter int DW = 32,
  parameter int SW = 16
) (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic [7:0]    addr,
  input  wire logic [31:0]   wdata,
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  output      logic [31:0]   rdata,
  input  wire logic          servo_on_pin,
  input  wire logic          drive_ready,
  input  wire logic          drive_fault,
  input  wire logic [DW-1:0] droop_count,
  input  wire logic [SW-1:0] speed_cmd,
  input  wire logic [SW-1:0] speed_meas,
  output      logic          in_position_flag,
  output      logic [2:0]    out_pin,
  output      logic          dyn_brake_cmd,
  output      logic          irq
);
  import sso_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        s3;
    logic        servo_on;
    logic        servo_on_d;
    sso_loop_t   loop;
    logic [15:0] range;
    logic [15:0] tol;
    logic [5:0]  assign_sel;
    logic        inp;
    logic        rdy;
    logic        dbi;
    logic        sa;
    logic        brake;
    logic [3:0]  ev;
    logic [3:0]  en;
    logic [31:0] rdata;
    logic [2:0]  pins;
  } sso_state_t;

  sso_state_t st;
  sso_state_t nx;

  // Magnitude of a signed value, saturating is not needed at these widths
  function automatic logic [DW:0] sso_abs(input logic signed [DW:0] v);
    sso_abs = v[DW] ? (-v) : v;
  endfunction : sso_abs

  logic [DW:0] droop_mag;
  logic [DW:0] cmd_mag;
  logic [DW:0] err_mag;
  logic        in_range;
  logic        on_rise;
  logic        near_speed;
  logic        low_cmd;
  logic        prepared;

  always_comb begin
    droop_mag  = sso_abs({droop_count[DW-1], droop_count});
    cmd_mag    = sso_abs((DW+1)'($signed(speed_cmd)));
    err_mag    = sso_abs((DW+1)'($signed(speed_meas)) - (DW+1)'($signed(speed_cmd)));
    in_range   = droop_mag <= (DW+1)'(st.range);                        // R1
    on_rise    = st.servo_on & ~st.servo_on_d;                           // R2
    near_speed = err_mag <= (DW+1)'(st.tol);                            // R9
    low_cmd    = cmd_mag <= (DW+1)'(`SSO_SA_LOW_RPM);                    // R10
    prepared   = st.servo_on & drive_ready & ~drive_fault;               // R5
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [3:0] set;
    logic [3:0] clr;
    set = 4'h0;
    clr = 4'h0;
    nx  = st;
    // Servo-on pin: third stage must agree with second before it counts
    nx.s1 = servo_on_pin;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    if (st.s2 == st.s3) begin
      nx.servo_on = st.s3;
    end
    nx.servo_on_d = st.servo_on;
    // Flags
    nx.inp   = (st.loop == SSO_LOOP_POS) & (in_range | on_rise);         // R1 R2 R3 R12
    nx.rdy   = prepared;                                                 // R5
    // Brake and interlock come from one term so they switch on one edge
    nx.brake = ~prepared;                                                // R6
    nx.dbi   = prepared;                                                 // R6
    nx.sa    = st.servo_on & (st.loop == SSO_LOOP_SPEED)
             & (near_speed | low_cmd);                                   // R8 R9 R10 R11
    // Only assigned outputs reach a pin; unassigned pins stay low
    for (int i = 0; i < 3; i++) begin
      case (sso_sel_t'(st.assign_sel[2*i +: 2]))                         // R4
        SSO_SEL_RDY: nx.pins[i] = st.rdy;
        SSO_SEL_DBI: nx.pins[i] = nx.dbi;
        SSO_SEL_SA:  nx.pins[i] = st.sa;
        default:     nx.pins[i] = 1'b0;
      endcase
    end
    // Events
    set[`SSO_EV_INP]   = nx.inp & ~st.inp;
    set[`SSO_EV_RDY]   = nx.rdy & ~st.rdy;
    set[`SSO_EV_SA]    = nx.sa & ~st.sa;
    set[`SSO_EV_BRAKE] = nx.brake & ~st.brake;
    // Register writes
    if (wr_en) begin
      case (addr)
        `SSO_CTRL_OFS:   nx.loop = sso_loop_t'(wdata[`SSO_CTRL_MODE_BIT]);
        `SSO_RANGE_OFS:  nx.range = wdata[15:0];
        `SSO_TOL_OFS:    nx.tol = wdata[15:0];
        `SSO_ASSIGN_OFS: nx.assign_sel = wdata[5:0];
        `SSO_ICLR_OFS:   clr = wdata[3:0];
        `SSO_IEN_OFS:    nx.en = wdata[3:0];
        default:         nx.en = st.en;
      endcase
    end
    // A new event wins over a clear in the same cycle
    nx.ev = (st.ev & ~clr) | set;
    // Register reads: data stand one cycle after the strobe only
    nx.rdata = 32'h0;
    if (rd_en) begin
      case (addr)
        `SSO_CTRL_OFS:   nx.rdata = {31'h0, st.loop == SSO_LOOP_SPEED};
        `SSO_RANGE_OFS:  nx.rdata = {16'h0, st.range};
        `SSO_TOL_OFS:    nx.rdata = {16'h0, st.tol};
        `SSO_ASSIGN_OFS: nx.rdata = {26'h0, st.assign_sel};
        `SSO_FLAGS_OFS:  nx.rdata = {26'h0, st.servo_on, st.brake, st.sa, st.dbi, st.rdy, st.inp};
        `SSO_IST_OFS:    nx.rdata = {28'h0, st.ev};
        `SSO_IEN_OFS:    nx.rdata = {28'h0, st.en};
        default:         nx.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st            <= '0;
      st.loop       <= SSO_LOOP_POS;
      st.range      <= `SSO_RANGE_RST;
      st.tol        <= `SSO_TOL_RST;
      st.assign_sel <= `SSO_ASSIGN_RST;
      st.brake      <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign rdata            = st.rdata;
  assign in_position_flag = st.inp;
  assign out_pin          = st.pins;
  assign dyn_brake_cmd    = st.brake;
  assign irq              = |(st.ev & st.en);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_inp_range;
    (in_range && st.loop == SSO_LOOP_POS) |=> st.inp;
  endproperty
  a_inp_range: assert property (p_inp_range) else $error("in-position missing in range"); // R1

  property p_inp_servo_on;
    (on_rise && st.loop == SSO_LOOP_POS) |=> st.inp;
  endproperty
  a_inp_servo_on: assert property (p_inp_servo_on) else $error("in-position missing at servo on"); // R2

  property p_inp_speed;
    st.loop == SSO_LOOP_SPEED |=> !st.inp;
  endproperty
  a_inp_speed: assert property (p_inp_speed) else $error("in-position in speed mode"); // R3

  property p_rdy;
    !(st.servo_on && drive_ready && !drive_fault) |=> !st.rdy ##0 st.brake;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready without servo on and prepared"); // R5

  property p_dbi;
    $rose(st.brake) |-> $fell(st.dbi);
  endproperty
  a_dbi: assert property (p_dbi) else $error("interlock not dropped with brake"); // R6

  property p_sa_off;
    !st.servo_on |=> !st.sa;
  endproperty
  a_sa_off: assert property (p_sa_off) else $error("speed reached while servo off"); // R8

  property p_sa_near;
    (st.servo_on && st.loop == SSO_LOOP_SPEED && near_speed) |=> st.sa;
  endproperty
  a_sa_near: assert property (p_sa_near) else $error("speed reached missing"); // R9

  property p_sa_low;
    (st.servo_on && st.loop == SSO_LOOP_SPEED && low_cmd) |=> st.sa;
  endproperty
  a_sa_low: assert property (p_sa_low) else $error("speed reached missing at low command"); // R10

  property p_sa_pos;
    st.loop == SSO_LOOP_POS |=> !st.sa;
  endproperty
  a_sa_pos: assert property (p_sa_pos) else $error("speed reached in position mode"); // R11

  property p_inp_leave;
    (!in_range && !on_rise) |=> !st.inp;
  endproperty
  a_inp_leave: assert property (p_inp_leave) else $error("in-position held out of range"); // R12

  property p_rdy_on;
    (st.servo_on && drive_ready && !drive_fault) |=> st.rdy;
  endproperty
  a_rdy_on: assert property (p_rdy_on) else $error("ready missing when prepared"); // R5

  property p_rdy_off;
    !st.servo_on |=> (!st.rdy && !st.dbi);
  endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready or interlock at servo off"); // R5 R6

  property p_dbi_fell;
    $fell(st.dbi) |-> $rose(st.brake);
  endproperty
  a_dbi_fell: assert property (p_dbi_fell) else $error("interlock dropped alone"); // R6

  // Interlock pin must switch on the same edge as the flag, not one later
  property p_pin_dbi;
    (sso_sel_t'(st.assign_sel[3:2]) == SSO_SEL_DBI) |=> (st.pins[1] == st.dbi);
  endproperty
  a_pin_dbi: assert property (p_pin_dbi) else $error("interlock pin lags flag"); // R6

  property p_pin_rdy;
    (sso_sel_t'(st.assign_sel[1:0]) == SSO_SEL_RDY) |=> (st.pins[0] == $past(st.rdy));
  endproperty
  a_pin_rdy: assert property (p_pin_rdy) else $error("ready pin wrong"); // R4 R5

  property p_pin_sa;
    (sso_sel_t'(st.assign_sel[5:4]) == SSO_SEL_SA) |=> (st.pins[2] == $past(st.sa));
  endproperty
  a_pin_sa: assert property (p_pin_sa) else $error("speed reached pin wrong"); // R4 R9

  property p_pin_none;
    (sso_sel_t'(st.assign_sel[1:0]) == SSO_SEL_NONE) |=> !st.pins[0];
  endproperty
  a_pin_none: assert property (p_pin_none) else $error("unassigned pin driven"); // R4

  property p_sa_only;
    !(near_speed || low_cmd) |=> !st.sa;
  endproperty
  a_sa_only: assert property (p_sa_only) else $error("speed reached off target"); // R9 R10

  // A glitch on the pin must not reach the flags before two stages agree
  property p_servo_sync;
    $changed(st.servo_on) |-> ($past(st.s2) == $past(st.s3));
  endproperty
  a_servo_sync: assert property (p_servo_sync) else $error("servo-on taken unsynced"); // R2

  property p_ev_inp;
    $rose(st.inp) |-> st.ev[`SSO_EV_INP];
  endproperty
  a_ev_inp: assert property (p_ev_inp) else $error("in-position event lost"); // R1 R2

  property p_ev_rdy;
    $rose(st.rdy) |-> st.ev[`SSO_EV_RDY];
  endproperty
  a_ev_rdy: assert property (p_ev_rdy) else $error("ready event lost"); // R5

  property p_ev_sa;
    $rose(st.sa) |-> st.ev[`SSO_EV_SA];
  endproperty
  a_ev_sa: assert property (p_ev_sa) else $error("speed reached event lost"); // R9

  property p_ev_brake;
    $rose(st.brake) |-> st.ev[`SSO_EV_BRAKE];
  endproperty
  a_ev_brake: assert property (p_ev_brake) else $error("brake event lost"); // R6

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_servo_on: cover property (on_rise ##1 st.inp);
  c_sa_rise: cover property (!st.sa ##1 st.sa);
  c_irq: cover property ($rose(irq));
  c_brake_engage: cover property ($rose(st.brake));
  c_inp_range: cover property (in_range ##1 st.inp);
endmodule : sso_status_outputs

// *** sim/sso_host_model.sv ***
// Host controller model that reads the assigned status pins
`timescale 1ns/10ps
module sso_host_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] out_pin,
  output      logic       host_ready,
  output      logic       host_dbi,
  output      logic       host_sa
);
  // Pins latched on the clock, as an input card would; meaning set by the assignment
  always_ff @(posedge ref_clk) begin
    host_ready <= out_pin[0];
    host_dbi   <= out_pin[1];
    host_sa    <= out_pin[2];
  end
endmodule : sso_host_model

// *** sim/tb.sv ***
// Self-checking bench of the servo status outputs
`timescale 1ns/10ps
`include "sso_map.svh"
module tb;
  import sso_pkg::*;
  logic        ref_clk, rst_n, wr_en, rd_en, servo_on_pin, drive_ready, drive_fault, seen;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, droop_count, seed;
  logic [15:0] speed_cmd, speed_meas;
  logic        in_position_flag, dyn_brake_cmd, irq, host_ready, host_dbi, host_sa;
  logic [2:0]  out_pin;
  int          mismatches, checks_done, k, c, m;
  sso_status_outputs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .servo_on_pin(servo_on_pin),
    .drive_ready(drive_ready), .drive_fault(drive_fault), .droop_count(droop_count),
    .speed_cmd(speed_cmd), .speed_meas(speed_meas), .in_position_flag(in_position_flag),
    .out_pin(out_pin), .dyn_brake_cmd(dyn_brake_cmd), .irq(irq));
  sso_host_model i_host (.ref_clk(ref_clk), .out_pin(out_pin), .host_ready(host_ready),
    .host_dbi(host_dbi), .host_sa(host_sa));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Tolerance follows its reset default; the low-speed limit is the fixed SSO_SA_LOW_RPM constant
  function automatic logic exp_sa(input int cm, input int ms);
    return (ms - cm <= int'(`SSO_TOL_RST) && cm - ms <= int'(`SSO_TOL_RST))
      || (cm <= int'(`SSO_SA_LOW_RPM) && cm >= -int'(`SSO_SA_LOW_RPM));
  endfunction : exp_sa
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic st(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : st
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge ref_clk);
    #1;
    chk(rdata, 32'h0);
  endtask : rd
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard
  initial begin
    #3000000;
    mismatches++;
    end_sim();
  end
  initial begin
    {rst_n, wr_en, rd_en, servo_on_pin, drive_ready, drive_fault} = '0;
    {addr, wdata, droop_count, speed_cmd, speed_meas} = '0;
    seed = 32'h6348cb31;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk(dyn_brake_cmd, 1'b1);
    rd(`SSO_RANGE_OFS, 32'h64);
    rd(`SSO_TOL_OFS, 32'h0a);
    rd(8'h40, 32'h0);
    wr(`SSO_ASSIGN_OFS, {26'h0, SSO_SEL_SA, SSO_SEL_DBI, SSO_SEL_RDY});
    wr(`SSO_IEN_OFS, 32'h1);
    droop_count <= 32'd1000;
    servo_on_pin <= 1'b1;
    seen = 1'b0;
    for (k = 0; k < 10 && !seen; k++) begin
      st(1);
      seen = (in_position_flag === 1'b1);
    end
    chk(seen, 1'b1);
    st(1);
    chk(in_position_flag, 1'b0);
    chk(irq, 1'b1);
    chk(out_pin[0], 1'b0);
    wr(`SSO_ICLR_OFS, 32'h1);
    st(1);
    chk(irq, 1'b0);
    rd(`SSO_FLAGS_OFS, 32'h30);
    for (k = 0; k < 12; k++) begin
      @(posedge ref_clk);
      c = int'(rnd() % 400) - 200;
      drive_ready <= 1'b1;
      droop_count <= 32'(c);
      drive_fault <= rnd() % 2 == 0;
      st(3);
      chk(in_position_flag, c <= 100 && c >= -100);
      chk(out_pin[0], !drive_fault);
      chk(host_ready, !drive_fault);
      chk(host_dbi, !drive_fault);
      chk(out_pin[1], !drive_fault);
      chk(dyn_brake_cmd, drive_fault);
    end
    wr(`SSO_CTRL_OFS, 32'h1);
    droop_count <= 32'h0;
    drive_fault <= 1'b0;
    st(3);
    chk(in_position_flag, 1'b0);
    for (k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      c = (k == 0) ? 15 : int'(rnd() % 80) - 40;
      m = (k == 0) ? 500 : c + int'(rnd() % 40) - 20;
      speed_cmd <= 16'(c);
      speed_meas <= 16'(m);
      st(3);
      chk(out_pin[2], exp_sa(c, m));
      chk(host_sa, exp_sa(c, m));
    end
    @(posedge ref_clk);
    servo_on_pin <= 1'b0;
    st(7);
    chk(out_pin[2], 1'b0);
    wr(`SSO_CTRL_OFS, 32'h0);
    servo_on_pin <= 1'b1;
    speed_meas <= speed_cmd;
    st(7);
    chk(out_pin[2], 1'b0);
    rd(`SSO_FLAGS_OFS, 32'h27);
    rd(`SSO_IST_OFS, 32'hf);
    wr(`SSO_ICLR_OFS, 32'hf);
    rd(`SSO_IST_OFS, 32'h0);
    wr(`SSO_RANGE_OFS, 32'h10);
    droop_count <= 32'h11;
    st(2);
    chk(in_position_flag, 1'b0);
    @(posedge ref_clk);
    droop_count <= 32'hfffffff0;
    st(2);
    chk(in_position_flag, 1'b1);
    chk(irq, 1'b1);
    end_sim();
  end
endmodule : tb
